//--- dac_serial_pkg.sv
// Constants and types shared by the serial load port of the DAC
package dac_serial_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Word format
  localparam int unsigned WORD_BITS = 16;
  localparam int unsigned COUNT_W   = 5;
  localparam logic [COUNT_W-1:0] COUNT_FULL = 5'h10;
  localparam logic [COUNT_W-1:0] COUNT_ZERO = 5'h00;
  localparam logic [COUNT_W-1:0] COUNT_ONE  = 5'h01;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values
  localparam logic [WORD_BITS-1:0] DAC_RESET   = 16'h0000;
  localparam logic [WORD_BITS-1:0] SHIFT_RESET = 16'h0000;

  ////////////////////////////////////////////////////////////////////////////
  // Link timing, for reference by the bench
  localparam int unsigned SYS_CLK_PERIOD_NS   = 10;
  localparam int unsigned SHIFT_CLK_PERIOD_NS = 125;
  localparam int unsigned SHIFT_CLK_CYCLES    = SHIFT_CLK_PERIOD_NS / SYS_CLK_PERIOD_NS;

  ////////////////////////////////////////////////////////////////////////////
  // Types
  typedef enum logic [0:0] {
    LINK_IDLE  = 1'b0,
    LINK_FRAME = 1'b1
  } link_state_t;

  // Pins of the link as seen inside the block
  typedef struct packed {
    logic shift_clk;
    logic serial_in;
    logic host_frame_strobe_n;
    logic load_output_n;
  } link_pins_t;

  localparam link_pins_t PINS_IDLE = '{shift_clk: 1'b1, serial_in: 1'b0,
                                       host_frame_strobe_n: 1'b1, load_output_n: 1'b1};

  // Whole state of the port
  typedef struct packed {
    link_pins_t             meta;
    link_pins_t             sync;
    link_pins_t             prev;
    link_state_t            state;
    logic [WORD_BITS-1:0]   shift;
    logic [WORD_BITS-1:0]   dac;
    logic [COUNT_W-1:0]     bits;
    logic                   word_ready;
    logic                   update;
  } port_state_t;

  localparam port_state_t PORT_RESET = '{meta: PINS_IDLE, sync: PINS_IDLE, prev: PINS_IDLE,
                                         state: LINK_IDLE, shift: SHIFT_RESET, dac: DAC_RESET,
                                         bits: COUNT_ZERO, word_ready: 1'b0, update: 1'b0};

endpackage

//--- dac_serial_load_port.sv
// Serial write and readback port of a 16-bit DAC
`timescale 1ns/1ns
`default_nettype none

module dac_serial_load_port
  import dac_serial_pkg::*;
(
  input  wire logic                 sys_clk,
  input  wire logic                 rst,
  input  wire logic                 shift_clk,
  input  wire logic                 serial_in,
  input  wire logic                 host_frame_strobe_n,
  input  wire logic                 load_output_n,
  output logic                      serial_out,
  output logic [WORD_BITS-1:0]      dac_value,
  output logic                      dac_update,
  output logic                      frame_active
);

  ////////////////////////////////////////////////////////////////////////////
  // State
  port_state_t          q;
  port_state_t          d;

  ////////////////////////////////////////////////////////////////////////////
  // Settled pin levels
  logic                 clk_now;
  logic                 clk_was;
  logic                 frame_now_n;
  logic                 frame_was_n;
  logic                 load_now_n;
  logic                 load_was_n;
  logic                 data_now;

  // Events on the link
  logic                 clk_fall;
  logic                 frame_start;
  logic                 frame_end;
  logic                 load_fall;
  logic                 load_low;

  // Frame and load decisions
  logic                 in_idle;
  logic                 in_frame;
  logic                 take_bit;
  logic                 strobe_load;

  // Shift path
  logic [WORD_BITS-1:0] shifted;
  logic [COUNT_W-1:0]   bits_next;
  logic                 bits_full;
  logic [COUNT_W-1:0]   bits_last;
  logic                 word_full;

  ////////////////////////////////////////////////////////////////////////////
  // Settled levels, current and one cycle older

  // Shift clock
  assign clk_now     = q.sync.shift_clk;
  assign clk_was     = q.prev.shift_clk;

  // Frame sync
  assign frame_now_n = q.sync.host_frame_strobe_n;
  assign frame_was_n = q.prev.host_frame_strobe_n;

  // Load strobe
  assign load_now_n  = q.sync.load_output_n;
  assign load_was_n  = q.prev.load_output_n;

  // Serial data, same latency as the clock
  assign data_now    = q.sync.serial_in;

  ////////////////////////////////////////////////////////////////////////////
  // Edge detection on synchronised pins

  // Shift clock fall takes a bit
  assign clk_fall    = clk_was & ~clk_now;
  // Frame sync fall opens a frame
  assign frame_start = frame_was_n & ~frame_now_n;
  // Frame sync rise closes it
  assign frame_end   = ~frame_was_n & frame_now_n;
  // Load strobe fall and level
  assign load_fall   = load_was_n & ~load_now_n;
  assign load_low    = ~load_now_n;

  // Where the port stands
  assign in_idle     = (q.state == LINK_IDLE);
  assign in_frame    = (q.state == LINK_FRAME);

  // Clock and data acted on only inside a frame
  assign take_bit    = in_frame & clk_fall;
  // Strobe acts only while idle with a whole word
  assign strobe_load = in_idle & load_fall & q.word_ready;

  ////////////////////////////////////////////////////////////////////////////
  // Shift toward the output end, new bit at the bottom
  assign shifted   = {q.shift[WORD_BITS-2:0], data_now};
  assign bits_full = (q.bits == COUNT_FULL);
  assign bits_next = bits_full ? COUNT_FULL : q.bits + COUNT_ONE;
  // Count as it stands once this cycle's bit is taken
  assign bits_last = take_bit ? bits_next : q.bits;
  assign word_full = (bits_last == COUNT_FULL);

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    // First stage takes the pins
    d.meta.shift_clk           = shift_clk;
    d.meta.serial_in           = serial_in;
    d.meta.host_frame_strobe_n = host_frame_strobe_n;
    d.meta.load_output_n       = load_output_n;

    // Second stage settles them
    d.sync = q.meta;

    // Third stage keeps the older level for edges
    d.prev = q.sync;

    // Held unless a branch below moves it; update cleared unless a branch sets it
    d.state      = q.state;
    d.shift      = q.shift;
    d.dac        = q.dac;
    d.bits       = q.bits;
    d.word_ready = q.word_ready;
    d.update     = 1'b0;

    case (q.state)
      LINK_IDLE: begin
        // Clock and data ignored outside a frame
        if (frame_start) begin
          // Register contents preloaded for readback
          d.shift = q.dac;
          d.bits  = COUNT_ZERO;
          d.state = LINK_FRAME;
        end else if (strobe_load) begin
          // Strobe after a complete word loads it
          d.dac        = q.shift;
          d.word_ready = 1'b0;
          d.update     = 1'b1;
        end else begin
          d.state = LINK_IDLE;
        end
      end

      LINK_FRAME: begin
        // Frame held low by host while shifting
        if (take_bit) begin
          // Past sixteen edges, input reappears delayed
          d.shift = shifted;
          d.bits  = bits_next;
        end
        if (frame_end) begin
          d.state = LINK_IDLE;
          if (load_low && word_full) begin
            // Load tied low: update on frame rise
            d.dac        = d.shift;
            d.word_ready = 1'b0;
            d.update     = 1'b1;
          end else begin
            // Load high or word short: DAC left as it was
            d.word_ready = word_full;
          end
        end else begin
          d.state = LINK_FRAME;
        end
      end

      default: begin
        d.state = LINK_IDLE;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  // Reset returns pins to idle levels, word and DAC to zero
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      q <= PORT_RESET;
    end else begin
      q <= d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  // Readback and chain output
  assign serial_out   = q.shift[WORD_BITS-1];

  // Word the DAC converts
  assign dac_value    = q.dac;

  // One cycle pulse on each load
  assign dac_update   = q.update;

  // High while a frame is open
  assign frame_active = in_frame;

endmodule

`default_nettype wire

//--- dac_serial_load_port_checker.sv
// Assertions on the DAC serial load port
`timescale 1ns/1ns
`default_nettype none
module dac_serial_load_port_checker (
  input wire logic        sys_clk,
  input wire logic        rst,
  input wire logic        host_frame_strobe_n,
  input wire logic        load_output_n,
  input wire logic        serial_out,
  input wire logic [15:0] dac_value,
  input wire logic        dac_update,
  input wire logic        frame_active
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  property p_hold; !dac_update |-> $stable(dac_value); endproperty
  a_hold: assert property (p_hold) else $error("hold");
  property p_pulse; dac_update |=> !dac_update; endproperty
  a_pulse: assert property (p_pulse) else $error("pulse");
  property p_idle; dac_update |-> !frame_active; endproperty
  a_idle: assert property (p_idle) else $error("idle");
  property p_start; $rose(frame_active) |-> !$past(host_frame_strobe_n, 2); endproperty
  a_start: assert property (p_start) else $error("start");
  property p_quiet; !frame_active |=> frame_active || $stable(serial_out); endproperty
  a_quiet: assert property (p_quiet) else $error("quiet");
  property p_pre; $rose(frame_active) |-> serial_out == dac_value[15]; endproperty
  a_pre: assert property (p_pre) else $error("preload");
  property p_rdbk; $fell(frame_active) && $past(load_output_n, 3) |-> !dac_update; endproperty
  a_rdbk: assert property (p_rdbk) else $error("readback");
  property p_src; dac_update |-> $past(frame_active) || !$past(load_output_n, 3); endproperty
  a_src: assert property (p_src) else $error("source");
endmodule
bind dac_serial_load_port dac_serial_load_port_checker chk (.*);
`default_nettype wire

//--- host_link_model.sv
// Host model driving the serial link
`timescale 1ns/1ns
`default_nettype none
module host_link_model (
  input  wire logic sys_clk,
  input  wire logic serial_out,
  output var logic  shift_clk,
  output var logic  serial_in,
  output var logic  host_frame_strobe_n,
  output var logic  load_output_n
);
  logic [31:0] rx;
  initial begin
    shift_clk = 1'b1;
    serial_in = 1'b0;
    host_frame_strobe_n = 1'b1;
    load_output_n = 1'b1;
  end
  task automatic xfer(input logic [31:0] w, input logic [5:0] n, input logic ld);
    @(negedge sys_clk);
    #2;
    rx = 32'h0;
    load_output_n = ld;
    host_frame_strobe_n = 1'b0;
    #62;
    for (int i = n - 1; i >= 0; i--) begin
      serial_in = w[i];
      #63;
      rx = {rx[30:0], serial_out};
      shift_clk = 1'b0;
      #62;
      shift_clk = 1'b1;
    end
    #63;
    host_frame_strobe_n = 1'b1;
    serial_in = ~serial_in;
    repeat (8) @(negedge sys_clk);
  endtask
  task automatic pulse;
    @(negedge sys_clk);
    load_output_n = 1'b0;
    repeat (4) @(negedge sys_clk);
    load_output_n = 1'b1;
    repeat (8) @(negedge sys_clk);
  endtask
endmodule
`default_nettype wire

//--- tb.sv
// Bench for the DAC serial load port
`timescale 1ns/1ns
`default_nettype none
module tb import dac_serial_pkg::*;;
  typedef struct packed {
    logic [31:0] w; logic [5:0] n; logic ld; logic [15:0] dac; logic [31:0] rx; logic [1:0] ups;
  } row_t;
  row_t rows [4] = '{'{32'h00001234, 6'h10, 1'b0, 16'h1234, 32'h00000000, 2'h1},
    '{32'hABCD5A5A, 6'h20, 1'b0, 16'h5A5A, 32'h1234ABCD, 2'h2},
    '{32'h000000C3, 6'h08, 1'b0, 16'h5A5A, 32'h0000005A, 2'h2},
    '{32'h00008001, 6'h10, 1'b1, 16'h5A5A, 32'h00005A5A, 2'h2}};
  logic sys_clk, rst, shift_clk, serial_in, host_frame_strobe_n, load_output_n, serial_out;
  logic dac_update, frame_active;
  logic [15:0] dac_value;
  logic [1:0] ups = 2'h0;
  int fail_count = 0;
  int checked = 0;
  dac_serial_load_port dut (.*);
  host_link_model host (.*);
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) if (dac_update === 1'b1) ups <= ups + 2'h1;
  task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %s exp %h got %h", nm, exp, got);
    end
  endtask
  task automatic close_out;
    $display("checked %0d failed %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    #60000;
    fail_count++;
    close_out();
  end
  initial begin
    rst = 1'b1;
    repeat (16) @(negedge sys_clk);
    rst = 1'b0;
    check("reset", 32'(DAC_RESET), 32'(dac_value));
    check("frame", 32'h0, 32'(frame_active));
    repeat (4) @(negedge sys_clk);
    foreach (rows[i]) begin
      host.xfer(rows[i].w, rows[i].n, rows[i].ld);
      check("dac", 32'(rows[i].dac), 32'(dac_value));
      check("readback", rows[i].rx, host.rx);
      check("updates", 32'(rows[i].ups), 32'(ups));
      $display("row %0d done", i);
    end
    host.pulse();
    check("pulse", 32'h00008001, 32'(dac_value));
    check("pulse_ups", 32'h3, 32'(ups));
    check("idle", 32'h0, 32'(frame_active));
    $display("pulse done");
    close_out();
  end
endmodule
`default_nettype wire
